// ### verilog/lpia_pkg.sv
// constants and types of the lowest-priority interrupt arbiter
package lpia_pkg;
  // *******************************************************
  // register map, byte addresses on the register port
  // *******************************************************
  localparam int unsigned AW = 8;
  localparam logic [7:0] A_TASK = 8'h00; // task priority, rw
  localparam logic [7:0] A_PROC = 8'h04; // processor prio, ro
  localparam logic [7:0] A_ARB = 8'h08; // arbitration value, ro
  localparam logic [7:0] A_CMDLO = 8'h0C; // command low, sends
  localparam logic [7:0] A_CMDHI = 8'h10; // command high
  localparam logic [7:0] A_LOGID = 8'h14; // logical id
  localparam logic [7:0] A_FMT = 8'h18; // target format
  localparam logic [7:0] A_EOS = 8'h1C; // end of service, wo
  localparam logic [7:0] A_STAT = 8'h20; // status
  localparam logic [7:0] A_ID = 8'h24; // own identifier
  localparam logic [7:0] A_HPV = 8'h28; // highest vectors, ro
  // *******************************************************
  // field positions and reset values
  // *******************************************************
  localparam int unsigned CMD_DLV_LSB = 8; // delivery [10:8]
  localparam int unsigned CMD_LOG_BIT = 11; // logical mode
  localparam int unsigned CMD_LVL_BIT = 14; // level
  localparam int unsigned CMD_TRG_BIT = 15; // trigger mode
  localparam int unsigned CMD_SH_LSB = 18; // shorthand [19:18]
  localparam int unsigned DEST_LSB = 24; // dest / logical id
  localparam int unsigned FMT_MODEL_LSB = 28; // model nibble
  localparam logic [3:0] FMT_FLAT = 4'hF; // flat model code
  localparam logic [31:0] FMT_RST = 32'hFFFF_FFFF;
  localparam int unsigned ST_BUSY = 0; // send engine busy
  localparam int unsigned ST_DROP = 1; // startup dropped
  localparam int unsigned ST_DISP = 2; // dispatch open
  // *******************************************************
  // types
  // *******************************************************
  typedef enum logic [2:0] {
    DLV_FIXED = 3'b000, DLV_LOWEST = 3'b001, DLV_SYSM = 3'b010,
    DLV_RSVD = 3'b011, DLV_NMI = 3'b100, DLV_INIT = 3'b101,
    DLV_START = 3'b110, DLV_EXTV = 3'b111
  } lpia_dlv_e;
  typedef enum logic [1:0] {
    SND_IDLE = 2'b00, SND_CMD = 2'b01, SND_EOS = 2'b10
  } lpia_snd_e;
endpackage

// ### verilog/lpia_prio_if.sv
// carrier between the top and the priority calculator
interface lpia_prio_if;
  logic [255:0] pend; // pending request bits
  logic [255:0] insv; // in-service bits
  logic [7:0] task_lvl; // task priority level
  logic [7:0] apv; // arbitration priority value
  logic [7:0] ppv; // processor priority level
  logic [7:0] hpv; // highest pending vector
  logic [7:0] hsv; // highest in-service vector
  logic any_insv; // some in-service bit set
  modport calc (input pend, insv, task_lvl,
    output apv, ppv, hpv, hsv, any_insv);
  modport user (output pend, insv, task_lvl,
    input apv, ppv, hpv, hsv, any_insv);
endinterface

// ### verilog/lpia_prio.sv
// combinational priority calculator: highest vectors and levels
module lpia_prio (
  lpia_prio_if.calc p
);
  import lpia_pkg::*;
  // *******************************************************
  // highest set bits; an empty array reads as vector 00
  // *******************************************************
  always_comb begin
    p.hpv = 8'h00;
    p.hsv = 8'h00;
    p.any_insv = |p.insv;
    for (int i = 0; i < 256; i++) begin
      if (p.pend[i]) begin
        p.hpv = 8'(i);
      end
      if (p.insv[i]) begin
        p.hsv = 8'(i);
      end
    end
  end
  // *******************************************************
  // levels follow their inputs with no register, so register
  // reads see the present state; the top registers apv onto ARB_PRIO
  // *******************************************************
  always_comb begin
    if (p.task_lvl[7:4] >= p.hpv[7:4] &&
        p.task_lvl[7:4] > p.hsv[7:4]) begin
      p.apv = p.task_lvl;
    end else if ((p.task_lvl[7:4] & p.hsv[7:4]) > p.hpv[7:4]) begin
      p.apv = {p.task_lvl[7:4] & p.hsv[7:4], 4'h0};
    end else begin
      p.apv = {p.hpv[7:4], 4'h0};
    end
    if (p.task_lvl[7:4] >= p.hsv[7:4]) begin
      p.ppv = p.task_lvl;
    end else begin
      p.ppv = {p.hsv[7:4], 4'h0};
    end
  end
endmodule

// ### verilog/lpia_top.sv
// local interrupt controller: messages, rotation and delivery
module lpia_top #(
  parameter logic [3:0] LOCAL_ID = 4'h0, // own identifier
  parameter bit FOCUS_EN = 1'b1, // older bus: focus allowed
  parameter int unsigned NVEC = 256 // vector count
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [lpia_pkg::AW-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic MSG_VALID,
  output lpia_pkg::lpia_dlv_e MSG_DLV,
  output logic [7:0] MSG_VEC,
  output logic [7:0] MSG_DEST,
  output logic MSG_LOGICAL,
  output logic [1:0] MSG_SHORT,
  output logic MSG_LEVEL,
  output logic MSG_TRIG,
  output logic MSG_DONE,
  input wire logic MSG_ACK,
  input wire logic MSG_NAK,
  input wire logic IN_VALID,
  input wire lpia_pkg::lpia_dlv_e IN_DLV,
  input wire logic [7:0] IN_VEC,
  input wire logic [7:0] IN_DEST,
  input wire logic IN_LOGICAL,
  input wire logic IN_BCAST,
  input wire logic IN_LEVEL,
  input wire logic IN_TRIG,
  input wire logic IN_LP_WIN,
  output logic [7:0] ARB_PRIO,
  output logic CORE_REQ,
  output lpia_pkg::lpia_dlv_e CORE_DLV,
  output logic [7:0] CORE_VEC,
  output logic INTR_VALID,
  output logic [7:0] INTR_VEC,
  input wire logic INTR_ACK,
  output logic TPR_RPT_VALID,
  output logic [7:0] TPR_RPT_VAL,
  input wire logic ROUND_DONE,
  input wire logic ROUND_WON,
  output logic [3:0] BUS_ROT_PRIO
);
  import lpia_pkg::*;

  // vectors are eight bits wide, so only 256 entries fit
  if (NVEC != 256) begin : g_chk
    $error("NVEC must be 256");
  end

  // *******************************************************
  // state
  // *******************************************************
  typedef struct packed {
    logic [7:0] task_lvl; // task priority level
    logic [31:0] cmd_lo; // command word, low half
    logic [31:0] cmd_hi; // command word, high half
    logic [31:0] logid; // logical id register
    logic [31:0] fmt; // target format register
    logic [3:0] id; // own identifier
    logic [3:0] rot; // hidden bus rotation priority
    logic [255:0] pend; // pending request bits
    logic [255:0] insv; // in-service bits
    logic [255:0] trig; // trigger mode per vector
    lpia_snd_e snd; // send engine state
    logic cmd_req; // command waiting for engine
    logic eos_req; // completion waiting for engine
    logic [7:0] eos_vec; // vector of that completion
    logic drop; // startup message dropped
    logic msg_valid;
    lpia_dlv_e msg_dlv;
    logic [7:0] msg_vec;
    logic [7:0] msg_dest;
    logic msg_log;
    logic [1:0] msg_sh;
    logic msg_lvl;
    logic msg_trg;
    logic msg_done;
    logic [7:0] arb;
    logic core_req;
    lpia_dlv_e core_dlv;
    logic [7:0] core_vec;
    logic intr_valid;
    logic [7:0] intr_vec;
    logic rpt_valid;
    logic [7:0] rpt_val;
    logic [31:0] rdata;
  } lpia_st_s;

  lpia_st_s st_ff; // registered state
  lpia_st_s nxt_st; // next state
  lpia_prio_if pif (); // carrier to calculator
  logic named; // this controller is a destination
  logic focus; // vector already pending or in service
  logic bypass; // type goes straight to core
  logic accept; // message taken this cycle
  logic wr_cmd; // command low word written
  logic wr_eos; // end of service written

  lpia_prio u_prio (
    .p(pif.calc)
  );

  assign pif.pend = st_ff.pend;
  assign pif.insv = st_ff.insv;
  assign pif.task_lvl = st_ff.task_lvl;

  // *******************************************************
  // acceptance decode
  // *******************************************************
  always_comb begin
    wr_cmd = WR && ADDR == A_CMDLO;
    wr_eos = WR && ADDR == A_EOS;
    // cluster model is not served: non-flat logical never hits
    if (IN_BCAST) begin
      named = 1'b1;
    end else if (IN_LOGICAL) begin
      named = st_ff.fmt[31:FMT_MODEL_LSB] == FMT_FLAT &&
        (IN_DEST & st_ff.logid[31:DEST_LSB]) != 8'h00;
    end else begin
      named = IN_DEST == {4'h0, st_ff.id} || IN_DEST == 8'hFF;
    end
    focus = FOCUS_EN && (st_ff.pend[IN_VEC] || st_ff.insv[IN_VEC]);
    bypass = IN_DLV inside {DLV_NMI, DLV_SYSM, DLV_INIT,
      DLV_EXTV, DLV_START};
    // lowest priority: the bus says who held the lowest value
    accept = IN_VALID && named &&
      (IN_DLV != DLV_LOWEST || IN_LP_WIN || focus);
  end

  // *******************************************************
  // next state
  // *******************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.core_req = 1'b0;
    nxt_st.rpt_valid = 1'b0;
    nxt_st.msg_done = st_ff.msg_done;
    nxt_st.arb = pif.apv;
    nxt_st.rdata = 32'h0000_0000;
    // register writes
    if (WR) begin
      unique case (ADDR)
        A_TASK: begin
          nxt_st.task_lvl = WDATA[7:0];
          nxt_st.rpt_valid = 1'b1;
          nxt_st.rpt_val = WDATA[7:0];
        end
        A_CMDLO: begin
          nxt_st.cmd_lo = WDATA;
          nxt_st.cmd_req = 1'b1;
        end
        A_CMDHI: nxt_st.cmd_hi = WDATA;
        A_LOGID: nxt_st.logid = WDATA;
        A_FMT: nxt_st.fmt = WDATA;
        A_ID: nxt_st.id = WDATA[3:0];
        A_STAT: begin
          if (WDATA[ST_DROP]) begin
            nxt_st.drop = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // reads answer one cycle later; unmapped reads give zero
    if (RD) begin
      unique case (ADDR)
        A_TASK: nxt_st.rdata = {24'h0, st_ff.task_lvl};
        A_PROC: nxt_st.rdata = {24'h0, pif.ppv};
        A_ARB: nxt_st.rdata = {24'h0, pif.apv};
        A_CMDLO: nxt_st.rdata = st_ff.cmd_lo;
        A_CMDHI: nxt_st.rdata = st_ff.cmd_hi;
        A_LOGID: nxt_st.rdata = st_ff.logid;
        A_FMT: nxt_st.rdata = st_ff.fmt;
        A_ID: nxt_st.rdata = {28'h0, st_ff.id};
        A_STAT: nxt_st.rdata = {29'h0, st_ff.intr_valid,
          st_ff.drop, st_ff.snd != SND_IDLE};
        A_HPV: nxt_st.rdata = {16'h0, pif.hsv, pif.hpv};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    // end of service: retire the top in-service vector
    if (wr_eos && pif.any_insv) begin
      nxt_st.insv[pif.hsv] = 1'b0;
      if (st_ff.trig[pif.hsv]) begin
        nxt_st.eos_req = 1'b1;
        nxt_st.eos_vec = pif.hsv;
      end
    end
    // core takes the offered vector into service
    if (st_ff.intr_valid && INTR_ACK) begin
      nxt_st.intr_valid = 1'b0;
      nxt_st.pend[st_ff.intr_vec] = 1'b0;
      nxt_st.insv[st_ff.intr_vec] = 1'b1;
    end else if (!st_ff.intr_valid && |st_ff.pend &&
                 pif.hpv[7:4] > pif.ppv[7:4]) begin
      // one vector at a time, only above processor level
      nxt_st.intr_valid = 1'b1;
      nxt_st.intr_vec = pif.hpv;
    end
    // incoming message; a set wins over the ack clear above
    if (accept) begin
      if (bypass) begin
        nxt_st.core_req = 1'b1;
        nxt_st.core_dlv = IN_DLV;
        nxt_st.core_vec = IN_VEC;
      end else begin
        nxt_st.pend[IN_VEC] = 1'b1;
        nxt_st.trig[IN_VEC] = IN_TRIG;
      end
    end
    // bus rotation priority
    if (accept && IN_DLV == DLV_INIT && !IN_LEVEL && IN_TRIG) begin
      nxt_st.rot = st_ff.id;
    end else if (ROUND_DONE && ROUND_WON) begin
      nxt_st.rot = 4'h0;
    end else if (ROUND_DONE) begin
      nxt_st.rot = st_ff.rot + 4'h1;
    end
    // send engine
    unique case (st_ff.snd)
      SND_IDLE: begin
        // completions go first so a level source can re-raise
        if (st_ff.eos_req) begin
          nxt_st.eos_req = wr_eos && pif.any_insv && st_ff.trig[pif.hsv];
          nxt_st.snd = SND_EOS;
          nxt_st.msg_valid = 1'b1;
          nxt_st.msg_done = 1'b1;
          nxt_st.msg_dlv = DLV_FIXED;
          nxt_st.msg_vec = st_ff.eos_vec;
          nxt_st.msg_dest = 8'hFF;
          nxt_st.msg_log = 1'b0;
          nxt_st.msg_sh = 2'b00;
          nxt_st.msg_lvl = 1'b0;
          nxt_st.msg_trg = 1'b1;
        end else if (st_ff.cmd_req) begin
          nxt_st.cmd_req = wr_cmd;
          nxt_st.snd = SND_CMD;
          nxt_st.msg_valid = 1'b1;
          nxt_st.msg_done = 1'b0;
          nxt_st.msg_dlv = lpia_dlv_e'(st_ff.cmd_lo[CMD_DLV_LSB+:3]);
          nxt_st.msg_vec = st_ff.cmd_lo[7:0];
          nxt_st.msg_dest = st_ff.cmd_hi[DEST_LSB+:8];
          nxt_st.msg_log = st_ff.cmd_lo[CMD_LOG_BIT];
          nxt_st.msg_sh = st_ff.cmd_lo[CMD_SH_LSB+:2];
          nxt_st.msg_lvl = st_ff.cmd_lo[CMD_LVL_BIT];
          nxt_st.msg_trg = st_ff.cmd_lo[CMD_TRG_BIT];
        end
      end
      SND_CMD, SND_EOS: begin
        if (MSG_ACK) begin
          nxt_st.msg_valid = 1'b0;
          nxt_st.snd = SND_IDLE;
        end else if (MSG_NAK && st_ff.msg_dlv == DLV_START &&
                     st_ff.snd == SND_CMD) begin
          // startup is never resent; flag it instead
          nxt_st.msg_valid = 1'b0;
          nxt_st.drop = 1'b1;
          nxt_st.snd = SND_IDLE;
        end
        // any other refusal keeps the message up: a target
        // that never answers holds the engine forever
      end
      default: begin
        nxt_st.snd = SND_IDLE;
        nxt_st.msg_valid = 1'b0;
      end
    endcase
  end

  // *******************************************************
  // state register
  // *******************************************************
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      st_ff <= '0;
      st_ff.fmt <= FMT_RST;
      st_ff.id <= LOCAL_ID;
      st_ff.rot <= LOCAL_ID;
      st_ff.snd <= SND_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // *******************************************************
  // outputs, each straight from the state register
  // *******************************************************
  assign RDATA = st_ff.rdata;
  assign MSG_VALID = st_ff.msg_valid;
  assign MSG_DLV = st_ff.msg_dlv;
  assign MSG_VEC = st_ff.msg_vec;
  assign MSG_DEST = st_ff.msg_dest;
  assign MSG_LOGICAL = st_ff.msg_log;
  assign MSG_SHORT = st_ff.msg_sh;
  assign MSG_LEVEL = st_ff.msg_lvl;
  assign MSG_TRIG = st_ff.msg_trg;
  assign MSG_DONE = st_ff.msg_done;
  assign ARB_PRIO = st_ff.arb;
  assign CORE_REQ = st_ff.core_req;
  assign CORE_DLV = st_ff.core_dlv;
  assign CORE_VEC = st_ff.core_vec;
  assign INTR_VALID = st_ff.intr_valid;
  assign INTR_VEC = st_ff.intr_vec;
  assign TPR_RPT_VALID = st_ff.rpt_valid;
  assign TPR_RPT_VAL = st_ff.rpt_val;
  assign BUS_ROT_PRIO = st_ff.rot;

  // *******************************************************
  // assertions and covers
  // *******************************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  a_rot_winner: assert property (ROUND_DONE && ROUND_WON &&
    !accept |=> BUS_ROT_PRIO == 4'h0)
    else $error("winner did not drop to zero");
  a_rot_loser: assert property (ROUND_DONE && !ROUND_WON &&
    !accept |=> BUS_ROT_PRIO == $past(BUS_ROT_PRIO) + 4'h1)
    else $error("loser did not step up");
  a_cmd_launch: assert property (wr_cmd && st_ff.snd == SND_IDLE &&
    !st_ff.eos_req |=> ##1 MSG_VALID && !MSG_DONE)
    else $error("command write sent nothing");
  a_nak_retry: assert property (MSG_VALID && MSG_NAK && !MSG_ACK &&
    MSG_DLV != DLV_START |=> MSG_VALID)
    else $error("refused message not held");
  a_start_drop: assert property (MSG_VALID && MSG_NAK && !MSG_ACK &&
    !MSG_DONE && MSG_DLV == DLV_START |=> !MSG_VALID && st_ff.drop)
    else $error("startup message resent");
  a_bypass_core: assert property (accept && bypass |=>
    CORE_REQ && CORE_VEC == $past(IN_VEC))
    else $error("special request not forwarded");
  a_fixed_pend: assert property (accept && !bypass |=>
    st_ff.pend[$past(IN_VEC)] && !CORE_REQ)
    else $error("fixed request not pending");
  a_not_named: assert property (IN_VALID && !named |=>
    !CORE_REQ && st_ff.pend == $past(st_ff.pend) ||
    $past(INTR_ACK))
    else $error("foreign message accepted");
  a_apv_copy: assert property (st_ff.task_lvl[7:4] >= pif.hpv[7:4]
    && st_ff.task_lvl[7:4] > pif.hsv[7:4] |=>
    ARB_PRIO == $past(st_ff.task_lvl))
    else $error("arbitration value not task level");
  a_apv_low: assert property (ARB_PRIO[3:0] != 4'h0 |->
    ARB_PRIO == $past(st_ff.task_lvl))
    else $error("low nibble set outside copy case");
  a_one_dispatch: assert property (INTR_VALID && !INTR_ACK |=>
    INTR_VALID && $stable(INTR_VEC))
    else $error("offered vector changed");
  a_eos_clear: assert property (wr_eos && pif.any_insv &&
    !(INTR_VALID && INTR_ACK && INTR_VEC == pif.hsv) |=>
    !st_ff.insv[$past(pif.hsv)])
    else $error("end write left vector in service");
  a_task_report: assert property (WR && ADDR == A_TASK |=>
    TPR_RPT_VALID && TPR_RPT_VAL == $past(WDATA[7:0]))
    else $error("task level not reported");

  c_cmd_ack: cover property (MSG_VALID && MSG_ACK && !MSG_DONE);
  c_lowest_won: cover property (accept && IN_DLV == DLV_LOWEST);
  c_eos_level: cover property (MSG_VALID && MSG_DONE);
  c_dispatch: cover property (INTR_VALID && INTR_ACK);
endmodule

// ### testbench/lpia_peer.sv
// far-side bus model: answers each outgoing message
module lpia_peer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic valid,
  input wire logic [3:0] naks,
  input wire logic [3:0] dly,
  output logic ack,
  output logic nak
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt; // cycles the offer has waited
  logic [3:0] left; // refusals still owed
  // per offer, naks refusals and then one ack, each dly cycles late
  // refusals are bounded: every target exists
  always_ff @(posedge clk) begin
    ack <= 1'b0;
    nak <= 1'b0;
    if (!rst_n || !valid) begin
      cnt <= 4'h0;
      left <= naks;
    end else if (!ack && !nak) begin
      if (cnt == dly) begin
        cnt <= 4'h0;
        if (left != 4'h0) begin
          nak <= 1'b1;
          left <= left - 4'h1;
        end else begin
          ack <= 1'b1;
        end
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// ### testbench/tb.sv
// self-checking bench for the interrupt arbiter top
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lpia_pkg::*;
  // ****
  // signals
  // ****
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic in_valid = 1'b0;
  lpia_dlv_e in_dlv = DLV_FIXED;
  logic [7:0] in_vec = 8'h00;
  logic [7:0] in_dest = 8'h00;
  logic in_logical = 1'b0;
  logic in_bcast = 1'b0;
  logic in_level = 1'b0;
  logic in_trig = 1'b0;
  logic in_lp_win = 1'b0;
  logic intr_ack = 1'b0;
  logic round_done = 1'b0;
  logic round_won = 1'b0;
  logic [3:0] naks = 4'h0; // refusals the peer gives
  logic [3:0] dly = 4'h0; // peer answer delay
  logic [31:0] rdata;
  logic msg_valid, msg_done, msg_level, msg_ack, msg_nak;
  logic msg_logical, msg_trig;
  logic [1:0] msg_short;
  lpia_dlv_e msg_dlv, core_dlv;
  logic [7:0] msg_vec, msg_dest, arb_prio, core_vec, intr_vec, tpr_val;
  logic core_req, intr_valid, tpr_rpt;
  logic [3:0] rot;
  int failures = 0;
  int checked = 0;
  int nk, ak;
  // task levels and the arbitration value each must give
  logic [7:0] tv [3] = '{8'h57, 8'h43, 8'h23};
  logic [7:0] av [3] = '{8'h57, 8'h40, 8'h00};
  lpia_dlv_e bt [4] = '{DLV_NMI, DLV_SYSM, DLV_START, DLV_EXTV};
  // ****
  // design and far side
  // ****
  lpia_top #(.LOCAL_ID(4'h5), .FOCUS_EN(1'b1), .NVEC(256)) lpia_top_inst (
    .CLK_SYS(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .MSG_VALID(msg_valid), .MSG_DLV(msg_dlv),
    .MSG_VEC(msg_vec), .MSG_DEST(msg_dest), .MSG_LOGICAL(msg_logical),
    .MSG_SHORT(msg_short), .MSG_LEVEL(msg_level), .MSG_TRIG(msg_trig),
    .MSG_DONE(msg_done),
    .MSG_ACK(msg_ack), .MSG_NAK(msg_nak), .IN_VALID(in_valid),
    .IN_DLV(in_dlv), .IN_VEC(in_vec), .IN_DEST(in_dest),
    .IN_LOGICAL(in_logical), .IN_BCAST(in_bcast), .IN_LEVEL(in_level),
    .IN_TRIG(in_trig), .IN_LP_WIN(in_lp_win), .ARB_PRIO(arb_prio),
    .CORE_REQ(core_req), .CORE_DLV(core_dlv), .CORE_VEC(core_vec),
    .INTR_VALID(intr_valid), .INTR_VEC(intr_vec), .INTR_ACK(intr_ack),
    .TPR_RPT_VALID(tpr_rpt), .TPR_RPT_VAL(tpr_val),
    .ROUND_DONE(round_done), .ROUND_WON(round_won), .BUS_ROT_PRIO(rot));
  lpia_peer lpia_peer_inst (.clk(clk), .rst_n(rst_n), .valid(msg_valid),
    .naks(naks), .dly(dly), .ack(msg_ack), .nak(msg_nak));
  always #10 clk = ~clk; // 50 MHz
  // ****
  // shared tasks
  // ****
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results();
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one-cycle write; returns after the taking edge settles
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(logic [7:0] a, string n, logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(n, rdata, e);
  endtask
  // incoming message; flags are logical, bcast, level, trig
  task automatic rx(lpia_dlv_e d, logic [7:0] v, logic [7:0] t,
                    logic [3:0] f, logic lp);
    @(posedge clk);
    in_valid <= 1'b1;
    in_dlv <= d;
    in_vec <= v;
    in_dest <= t;
    {in_logical, in_bcast, in_level, in_trig} <= f;
    in_lp_win <= lp;
    @(posedge clk);
    in_valid <= 1'b0;
    #1;
  endtask
  task automatic round(logic won);
    @(posedge clk);
    round_done <= 1'b1;
    round_won <= won;
    @(posedge clk);
    round_done <= 1'b0;
    #1;
  endtask
  // bounded wait for the dispatch or the message offer
  task automatic wait_hi(logic intr);
    int i;
    for (i = 0; i < 50; i++) begin
      if ((intr ? intr_valid : msg_valid) === 1'b1) return;
      @(posedge clk);
      #1;
    end
    failures++;
    results();
  endtask
  // count peer answers until the offer is withdrawn
  task automatic drain(output int n, output int a);
    int i;
    n = 0;
    a = 0;
    for (i = 0; i < 99; i++) begin
      @(posedge clk);
      n += int'(msg_nak);
      a += int'(msg_ack);
      #1;
      if (msg_valid !== 1'b1) break;
    end
    if (i == 99) begin
      failures++;
      results();
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    chk("rotation", 32'(rot), 32'h5);
    rd_reg(A_ID, "own id", 32'h5);
    rd_reg(A_FMT, "format", FMT_RST);
    rd_reg(8'h3C, "unmapped", 32'h0);
  endtask
  task automatic t_rotation();
    int i;
    round(1'b0);
    chk("loser", 32'(rot), 32'h6);
    round(1'b1);
    chk("winner", 32'(rot), 32'h0);
    for (i = 0; i < 15; i++) begin
      round(1'b0);
    end
    chk("top", 32'(rot), 32'hF);
    round(1'b0);
    chk("wrap", 32'(rot), 32'h0);
  endtask
  // new id, then init deassert must reload the rotation
  task automatic t_init();
    round(1'b0);
    wr_reg(A_ID, 32'h9);
    rx(DLV_INIT, 8'h00, 8'h09, 4'b0001, 1'b0);
    chk("init core", 32'(core_req), 32'h1);
    @(posedge clk);
    #1;
    chk("reload", 32'(rot), 32'h9);
  endtask
  // no end-of-service write follows these requests
  task automatic t_bypass();
    int i;
    for (i = 0; i < 4; i++) begin
      rx(bt[i], 8'(8'h20 + i), 8'h09, 4'b0000, 1'b0);
      chk("core req", 32'(core_req), 32'h1);
      chk("core type", 32'(core_dlv), 32'(bt[i]));
      chk("core vec", 32'(core_vec), 32'(8'h20 + i));
    end
    rd_reg(A_HPV, "bypass", 32'h0);
  endtask
  task automatic t_fixed();
    int i;
    wr_reg(A_TASK, 32'h50);
    chk("report", 32'(tpr_rpt), 32'h1);
    chk("report val", 32'(tpr_val), 32'h50);
    rx(DLV_FIXED, 8'h52, 8'h03, 4'b0000, 1'b0);
    rd_reg(A_HPV, "not named", 32'h0);
    rx(DLV_FIXED, 8'h41, 8'h09, 4'b0001, 1'b0);
    rd_reg(A_HPV, "pending", 32'h41);
    rd_reg(A_ARB, "task copy", 32'h50);
    chk("gated", 32'(intr_valid), 32'h0);
    wr_reg(A_TASK, 32'h30);
    rd_reg(A_ARB, "pend nibble", 32'h40);
    chk("arb port", 32'(arb_prio), 32'h40);
    wait_hi(1'b1);
    chk("dispatch", 32'(intr_vec), 32'h41);
    @(posedge clk);
    intr_ack <= 1'b1;
    @(posedge clk);
    intr_ack <= 1'b0;
    rd_reg(A_HPV, "in service", 32'h4100);
    for (i = 0; i < 3; i++) begin
      wr_reg(A_TASK, 32'(tv[i]));
      rd_reg(A_ARB, "arb", 32'(av[i]));
    end
    rd_reg(A_PROC, "proc", 32'h40);
  endtask
  // slow peer so the completion offer is seen whole
  task automatic t_eos();
    dly <= 4'h3;
    wr_reg(A_EOS, 32'h0);
    rd_reg(A_HPV, "cleared", 32'h0);
    wait_hi(1'b0);
    chk("done", 32'(msg_done), 32'h1);
    chk("done vec", 32'(msg_vec), 32'h41);
    chk("done dest", 32'(msg_dest), 32'hFF);
    chk("done type", 32'(msg_dlv), 32'(DLV_FIXED));
    drain(nk, ak);
  endtask
  task automatic t_lowest();
    wr_reg(A_LOGID, 32'h0A00_0000);
    rx(DLV_LOWEST, 8'h71, 8'h02, 4'b1000, 1'b0);
    rd_reg(A_HPV, "lost", 32'h0);
    rx(DLV_LOWEST, 8'h61, 8'h04, 4'b1000, 1'b1);
    rd_reg(A_HPV, "flat miss", 32'h0);
    rx(DLV_LOWEST, 8'h61, 8'h02, 4'b1000, 1'b1);
    rd_reg(A_HPV, "lowest", 32'h61);
    rx(DLV_FIXED, 8'h75, 8'h30, 4'b0100, 1'b0);
    rd_reg(A_HPV, "broadcast", 32'h75);
  endtask
  // prompt peer refusing twice, then a refused startup
  task automatic t_command();
    dly <= 4'h0;
    naks <= 4'h2;
    wr_reg(A_CMDHI, 32'h0200_0000);
    wr_reg(A_CMDLO, 32'h0004_C833);
    wait_hi(1'b0);
    chk("cmd vec", 32'(msg_vec), 32'h33);
    chk("cmd dest", 32'(msg_dest), 32'h02);
    chk("cmd type", 32'(msg_dlv), 32'(DLV_FIXED));
    chk("cmd level", 32'(msg_level), 32'h1);
    chk("cmd logical", 32'(msg_logical), 32'h1);
    chk("cmd short", 32'(msg_short), 32'h1);
    chk("cmd trig", 32'(msg_trig), 32'h1);
    drain(nk, ak);
    chk("retries", 32'(nk), 32'h2);
    chk("delivered", 32'(ak), 32'h1);
    naks <= 4'h1;
    wr_reg(A_CMDLO, 32'h0000_0633);
    wait_hi(1'b0);
    drain(nk, ak);
    chk("startup once", 32'(nk + ak), 32'h1);
    rd_reg(A_STAT, "status", 32'h6);
    wr_reg(A_STAT, 32'h2);
    rd_reg(A_STAT, "drop clear", 32'h4);
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_rotation();
    t_init();
    t_bypass();
    t_fixed();
    t_eos();
    t_lowest();
    t_command();
    results();
  end
endmodule
